/* File: rtl/nac_ctrl.sv */
/*
 * Nonvolatile access controller: control/data/address registers, armed
 * write sequence, read strobe, CPU stall, ready interrupt.
 * Assumes an I/O bus with byte strobes in ref_clk, an RC tick pulse, and a
 * status level from the flash self-program unit.
 */
`timescale 1ns/1ns
module nac_ctrl
  import nac_pkg::*;
#(
  parameter int AW = NAC_ADDR_W,
  parameter int RC_WRITE = NAC_RC_WRITE_CYCLES,
  parameter int RC_SPLIT = NAC_RC_SPLIT_CYCLES,
  parameter int CW = 15
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [7:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic io_we,
  input wire logic io_re,
  input wire logic rc_tick,
  input wire logic self_program_active,
  input wire logic global_irq_enable,
  output logic [7:0] io_rdata,
  output logic cpu_stall,
  output logic ready_irq
);
  // Gray-coded engine states
  typedef enum logic [1:0] {
    NAC_IDLE = 2'b00,
    NAC_PROG = 2'b01,
    NAC_FINISH = 2'b11
  } nac_state_e;

  nac_state_e state_reg; // Programming engine state
  logic [1:0] mode_reg; // program_mode_field
  logic rie_reg; // ready_irq_enable
  logic arm_reg; // master_write_arm
  logic [2:0] arm_cnt_reg; // Cycles left in arm window
  logic start_reg; // program_start_flag
  logic read_reg; // read_strobe_bit, reads zero after the read
  logic [7:0] nvm_data_reg; // Data register
  logic [AW-1:0] nvm_address_reg; // Address register
  logic [2:0] stall_cnt_reg; // CPU stall cycles left
  logic prog_busy; // Array programming in progress
  logic timer_load; // Start of programming
  logic timer_done; // Programming time elapsed
  logic [CW-1:0] timer_val; // Ticks for chosen mode
  logic [7:0] ctl_view; // Read view of control register
  logic [7:0] rdata_next; // Read mux
  logic wr_ctl, wr_data, wr_alo, wr_ahi, start_req;
  logic [1:0] mode_latched_reg; // Mode captured at start

  nac_array_if #(.AW(AW)) arr ();

  // Strobe decode, used for each register
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs, input logic we);
    hit = we && (a == ofs);
  endfunction : hit

  assign wr_ctl = hit(io_addr, NAC_OFS_CONTROL, io_we);
  assign wr_data = hit(io_addr, NAC_OFS_DATA, io_we);
  assign wr_alo = hit(io_addr, NAC_OFS_ADDR_LO, io_we);
  assign wr_ahi = hit(io_addr, NAC_OFS_ADDR_HI, io_we);
  // Start honoured only inside arm window, idle, no self-program, valid mode
  assign start_req = wr_ctl && io_wdata[NAC_BIT_START] && arm_reg && !start_reg
    && !self_program_active
    && (mode_reg != NAC_MODE_RSVD);
  assign timer_load = start_req;
  // Atomic takes the full write time; split modes the shorter one
  assign timer_val = (mode_reg == NAC_MODE_ATOMIC) ? CW'(RC_WRITE) : CW'(RC_SPLIT);

  nac_rc_timer #(.CW(CW)) u_timer (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .load(timer_load),
    .load_val(timer_val),
    .rc_tick(rc_tick),
    .busy(prog_busy),
    .done(timer_done)
  );

  nac_array #(.DEPTH(1 << AW)) u_array (
    .ref_clk(ref_clk),
    .clk_en(clk_en),
    .arr(arr)
  );

  // Array strobes fire at the end of the timed period
  assign arr.addr = nvm_address_reg;
  assign arr.wdata = nvm_data_reg;
  assign arr.erase = timer_done && (mode_latched_reg != NAC_MODE_WRITE);
  assign arr.write = timer_done && (mode_latched_reg != NAC_MODE_ERASE);

  // Engine: idle, programming, one finishing cycle; reset returns it to idle,
  // and the timer below clears its own count on reset as well
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= NAC_IDLE;
    end else if (clk_en) begin
      case (state_reg)
        NAC_IDLE: if (start_req) state_reg <= NAC_PROG;
        NAC_PROG: if (timer_done) state_reg <= NAC_FINISH;
        NAC_FINISH: state_reg <= NAC_IDLE;
        default: state_reg <= NAC_IDLE;
      endcase
    end
  end

  // Start flag: set on an armed start, cleared when time elapses
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      start_reg <= 1'b0;
    end else if (clk_en) begin
      if (start_req) begin
        start_reg <= 1'b1;
      end else if (timer_done) begin
        start_reg <= 1'b0;
      end else if (prog_busy) begin
        start_reg <= 1'b1;
      end
    end
  end

  // Mode field; cleared after any reset, since the timer count also resets and busy reads low.
  // The async reset cannot look at busy, so the clear happens synchronously
  // on the first edge after release instead.
  logic rst_seen_reg; // Low until first edge after reset
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_seen_reg <= 1'b0;
    end else if (clk_en) begin
      rst_seen_reg <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (clk_en) begin
      if (!rst_seen_reg && !prog_busy) begin
        mode_reg <= NAC_MODE_RESET;
      end else if (wr_ctl && !start_reg) begin
        mode_reg <= io_wdata[NAC_BIT_MODE_HI:NAC_BIT_MODE_LO];
      end
      if (start_req) begin
        mode_latched_reg <= mode_reg;
      end
    end
  end

  // Interrupt enable
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rie_reg <= 1'b0;
    end else if (clk_en && wr_ctl) begin
      rie_reg <= io_wdata[NAC_BIT_RIE];
    end
  end

  // Arm bit with four-cycle window; a start consumes it
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      arm_reg <= 1'b0;
      arm_cnt_reg <= '0;
    end else if (clk_en) begin
      if (wr_ctl && io_wdata[NAC_BIT_ARM] && !io_wdata[NAC_BIT_START] && !start_reg) begin
        arm_reg <= 1'b1;
        arm_cnt_reg <= NAC_ARM_CYCLES;
      end else if (start_req || arm_cnt_reg == 3'h1) begin
        arm_reg <= 1'b0;
        arm_cnt_reg <= '0;
      end else if (arm_reg) begin
        arm_cnt_reg <= arm_cnt_reg - 3'h1;
      end
    end
  end

  // Read strobe: one-cycle pulse; blocked while programming.
  // It drops on the next edge, so a later readback shows zero.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      read_reg <= 1'b0;
    end else if (clk_en) begin
      read_reg <= wr_ctl && io_wdata[NAC_BIT_READ] && !start_reg && !prog_busy && !read_reg;
    end
  end

  // Data register: software write, or byte read from the array
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      nvm_data_reg <= NAC_DATA_RESET;
    end else if (clk_en) begin
      if (wr_ctl && io_wdata[NAC_BIT_READ] && !start_reg && !prog_busy) begin
        nvm_data_reg <= arr.rdata;
      end else if (wr_data) begin
        nvm_data_reg <= io_wdata;
      end
    end
  end

  // Address register, no reset value; frozen during programming
  always_ff @(posedge ref_clk) begin
    if (clk_en && !start_reg && !prog_busy) begin
      if (wr_alo) begin
        nvm_address_reg[7:0] <= io_wdata;
      end
      if (wr_ahi) begin
        nvm_address_reg[AW-1:8] <= io_wdata[AW-9:0];
      end
    end
  end

  // CPU stall: two cycles after a start, four after a read
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      stall_cnt_reg <= '0;
      cpu_stall <= 1'b0;
    end else if (clk_en) begin
      if (start_req) begin
        stall_cnt_reg <= NAC_WSTALL_CYCLES - 3'h1;
        cpu_stall <= 1'b1;
      end else if (wr_ctl && io_wdata[NAC_BIT_READ] && !start_reg && !prog_busy) begin
        stall_cnt_reg <= NAC_RSTALL_CYCLES - 3'h1;
        cpu_stall <= 1'b1;
      end else if (stall_cnt_reg != '0) begin
        stall_cnt_reg <= stall_cnt_reg - 3'h1;
      end else begin
        cpu_stall <= 1'b0;
      end
    end
  end

  // Ready interrupt level
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ready_irq <= 1'b0;
    end else if (clk_en) begin
      ready_irq <= rie_reg && global_irq_enable && !start_reg
        && !prog_busy && !self_program_active && !start_req;
    end
  end

  // Read data mux, registered
  always_comb begin
    ctl_view = NAC_CONTROL_RESET;
    ctl_view[NAC_BIT_MODE_HI:NAC_BIT_MODE_LO] = mode_reg;
    ctl_view[NAC_BIT_RIE] = rie_reg;
    ctl_view[NAC_BIT_ARM] = arm_reg;
    ctl_view[NAC_BIT_START] = start_reg;
    ctl_view[NAC_BIT_READ] = read_reg;
    case (io_addr)
      NAC_OFS_CONTROL: rdata_next = ctl_view;
      NAC_OFS_DATA: rdata_next = nvm_data_reg;
      NAC_OFS_ADDR_LO: rdata_next = nvm_address_reg[7:0];
      NAC_OFS_ADDR_HI: rdata_next = {{(16-AW){1'b0}}, nvm_address_reg[AW-1:8]};
      default: rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      io_rdata <= 8'h00;
    end else if (clk_en && io_re) begin
      io_rdata <= rdata_next;
    end
  end

  // Checks
  chk_arm_timeout: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (clk_en && wr_ctl && io_wdata[NAC_BIT_ARM] && !io_wdata[NAC_BIT_START] && !start_reg) ##1 clk_en[*4]
    |=> !arm_reg) else $error("arm bit not cleared");
  chk_start_needs_arm: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $rose(start_reg) |-> $past(arm_reg)) else $error("start without arm");
  chk_irq_busy_off: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (clk_en && (prog_busy || self_program_active)) |=> !ready_irq) else $error("irq during programming");
  chk_irq_ready_on: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (clk_en && rie_reg && global_irq_enable && !start_reg && !prog_busy && !self_program_active && !start_req)
    |=> ready_irq) else $error("irq missing");
  chk_mode_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (start_reg && rst_seen_reg) |=> $stable(mode_reg)) else $error("mode changed while busy");
  chk_wstall_two: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (clk_en && start_req) ##1 clk_en |=> cpu_stall) else $error("write stall short");
  chk_no_rsvd: assert property (@(posedge ref_clk) disable iff (!reset_n)
    start_req |-> mode_reg != NAC_MODE_RSVD) else $error("reserved mode started");
  chk_done_clears: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (clk_en && timer_done && !start_req) |=> !start_reg) else $error("start flag stuck");
  chk_read_self_clr: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (clk_en && read_reg) |=> !read_reg) else $error("read strobe stuck");
  cov_write: cover property (@(posedge ref_clk) start_req);
  cov_done: cover property (@(posedge ref_clk) timer_done);
  cov_irq: cover property (@(posedge ref_clk) $rose(ready_irq));
endmodule : nac_ctrl

/* File: rtl/nac_pkg.sv */
/*
 * Package for the nonvolatile access controller: register offsets, field
 * positions, reset values, program modes and timing counts.
 * Assumes a CPU-side I/O bus with byte data and a 10 MHz ref_clk.
 */
package nac_pkg;
  // I/O offsets of the control, data and address registers
  localparam logic [7:0] NAC_OFS_CONTROL = 8'h3F;
  localparam logic [7:0] NAC_OFS_DATA = 8'h40;
  localparam logic [7:0] NAC_OFS_ADDR_LO = 8'h41;
  localparam logic [7:0] NAC_OFS_ADDR_HI = 8'h42;
  // Control register field positions
  localparam int NAC_BIT_READ = 0;
  localparam int NAC_BIT_START = 1;
  localparam int NAC_BIT_ARM = 2;
  localparam int NAC_BIT_RIE = 3;
  localparam int NAC_BIT_MODE_LO = 4;
  localparam int NAC_BIT_MODE_HI = 5;
  // Reset values
  localparam logic [7:0] NAC_CONTROL_RESET = 8'h00;
  localparam logic [7:0] NAC_DATA_RESET = 8'h00;
  localparam logic [1:0] NAC_MODE_RESET = 2'h0;
  // Address width for the 1K byte space (0..1023)
  localparam int NAC_ADDR_W = 10;
  // Program modes
  typedef enum logic [1:0] {
    NAC_MODE_ATOMIC = 2'h0,
    NAC_MODE_ERASE = 2'h1,
    NAC_MODE_WRITE = 2'h2,
    NAC_MODE_RSVD = 2'h3
  } nac_mode_e;
  // Arm window and stall lengths in clock cycles
  localparam logic [2:0] NAC_ARM_CYCLES = 3'h4;
  localparam logic [2:0] NAC_WSTALL_CYCLES = 3'h2;
  localparam logic [2:0] NAC_RSTALL_CYCLES = 3'h4;
  // RC oscillator cycles for a CPU write; split modes take 18/34 of that
  localparam int NAC_RC_WRITE_CYCLES = 26368;
  localparam int NAC_RC_SPLIT_CYCLES = (NAC_RC_WRITE_CYCLES * 18) / 34;
endpackage : nac_pkg

/* File: rtl/nac_array_if.sv */
/*
 * Interface between the controller and its byte array.
 * Assumes one clock shared by both ends.
 */
`timescale 1ns/1ns
interface nac_array_if #(parameter int AW = 10);
  logic [AW-1:0] addr; // Byte address
  logic [7:0] wdata; // Byte to program
  logic [7:0] rdata; // Byte read back, combinational
  logic erase; // One-cycle erase pulse
  logic write; // One-cycle write pulse
  modport ctrl (output addr, output wdata, output erase, output write, input rdata);
  modport mem (input addr, input wdata, input erase, input write, output rdata);
endinterface : nac_array_if

/* File: rtl/nac_array.sv */
/*
 * Flip-flop byte array standing in for the EEPROM cells.
 * Erase sets a byte to FF; write ANDs new bits in, as cells only clear.
 */
`timescale 1ns/1ns
module nac_array
  import nac_pkg::*;
#(
  parameter int DEPTH = 1024
) (
  input wire logic ref_clk,
  input wire logic clk_en,
  nac_array_if.mem arr
);
  logic [7:0] cell_reg [DEPTH]; // Storage, no reset as contents are nonvolatile

  // Erase and write pulses; both in one cycle give an atomic program
  always_ff @(posedge ref_clk) begin
    if (clk_en && (arr.erase || arr.write)) begin
      cell_reg[arr.addr] <= (arr.erase ? 8'hFF : cell_reg[arr.addr]) & (arr.write ? arr.wdata : 8'hFF);
    end
  end

  assign arr.rdata = cell_reg[arr.addr]; // Asynchronous read path
endmodule : nac_array

/* File: rtl/nac_rc_timer.sv */
/*
 * Programming timer counting calibrated RC oscillator ticks.
 * Assumes rc_tick is a one-cycle pulse synchronous to ref_clk.
 */
`timescale 1ns/1ns
module nac_rc_timer
  import nac_pkg::*;
#(
  parameter int CW = 15
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic load,
  input wire logic [CW-1:0] load_val,
  input wire logic rc_tick,
  output logic busy,
  output logic done
);
  logic [CW-1:0] cnt_reg; // Remaining oscillator ticks

  // Loads on start, counts down on ticks, pulses done at zero
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_reg <= '0;
      done <= 1'b0;
    end else if (clk_en) begin
      done <= 1'b0;
      if (load) begin
        cnt_reg <= load_val;
      end else if (busy && rc_tick) begin
        cnt_reg <= cnt_reg - 1'b1;
        done <= (cnt_reg == CW'(1));
      end
    end
  end
  assign busy = (cnt_reg != '0);
endmodule : nac_rc_timer

/* File: testbench/nac_far_side.sv */
/*
 * Model of what stands beyond the controller: the calibrated RC oscillator
 * tick and the flash self-program unit's busy level.
 * Assumes ref_clk at 10 MHz and a bench that requests self-program activity.
 */
`timescale 1ns/1ns
module nac_far_side (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic spm_req,
  output logic rc_tick,
  output logic self_program_active
);
  // Divider that spaces the oscillator ticks; slower than ref_clk on purpose
  logic [1:0] div_reg;

  // One-cycle tick every fourth clock, so programming spans many bus cycles
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_reg <= 2'h0;
      rc_tick <= 1'b0;
    end else begin
      div_reg <= div_reg + 2'h1;
      rc_tick <= (div_reg == 2'h3);
    end
  end

  // Flash self-program busy level, registered like the real status flag
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      self_program_active <= 1'b0;
    end else begin
      self_program_active <= spm_req;
    end
  end
endmodule : nac_far_side

/* File: testbench/nac_ctrl_bench.sv */
/*
 * Self-checking bench for the nonvolatile access controller: register
 * accesses on the I/O strobes, armed writes in every mode, refusals,
 * stalls, interlocks, ready interrupt and reset behaviour.
 * Assumes nac_pkg, nac_ctrl and nac_far_side are compiled first.
 */
`timescale 1ns/1ns
module nac_ctrl_bench;
  import nac_pkg::*;
  logic ref_clk, reset_n, io_we, io_re, gie, spm_req; // Bench-driven inputs
  logic [7:0] io_addr, io_wdata, io_rdata, v; // Bus and scratch value
  logic cpu_stall, ready_irq, rc_tick, self_program_active; // Observed lines
  int err_count, cmp_count; // Mismatches and comparisons made

  nac_far_side far (.ref_clk(ref_clk), .reset_n(reset_n), .spm_req(spm_req), .rc_tick(rc_tick),
    .self_program_active(self_program_active));
  // Short programming counts keep the run brief
  nac_ctrl #(.RC_WRITE(5), .RC_SPLIT(3)) dut (.ref_clk(ref_clk), .reset_n(reset_n), .clk_en(1'b1),
    .io_addr(io_addr), .io_wdata(io_wdata), .io_we(io_we), .io_re(io_re), .rc_tick(rc_tick),
    .self_program_active(self_program_active), .global_irq_enable(gie), .io_rdata(io_rdata),
    .cpu_stall(cpu_stall), .ready_irq(ready_irq));

  // Free-running 100 ns clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // Verdict and end of run, shared by the main sequence and the timeout
  task automatic report_and_stop;
    $display("checks %0d errors %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop

  // Compare one byte, counting and reporting a mismatch
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // One write strobe; the edge after launch takes it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    io_we <= 1'b1;
    io_addr <= a;
    io_wdata <= d;
    @(posedge ref_clk);
    io_we <= 1'b0;
  endtask : wr

  // One read strobe; data is registered at the taking edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    io_re <= 1'b1;
    io_addr <= a;
    @(posedge ref_clk);
    io_re <= 1'b0;
    #1 d = io_rdata;
  endtask : rd

  // Count settled cycles with the CPU stall high, bounded
  task automatic stall_len(output logic [7:0] n);
    n = 8'h00;
    #1;
    while (cpu_stall === 1'b1 && n < 8'h10) begin
      n++;
      @(posedge ref_clk);
      #1;
    end
  endtask : stall_len

  // Poll the busy flag; a hang ends the run as a failure
  task automatic wait_idle;
    int i;
    for (i = 0; i < 100; i++) begin
      rd(NAC_OFS_CONTROL, v);
      if (v[NAC_BIT_START] === 1'b0) break;
    end
    if (i == 100) begin
      err_count++;
      $display("[ERR] busy flag never cleared");
      report_and_stop;
    end
  endtask : wait_idle

  // Program one byte, then read it back through the read strobe
  task automatic prog(input logic [1:0] m, input logic [7:0] d, input logic [7:0] exp, input logic arm,
    input logic ok);
    logic [7:0] n;
    wr(NAC_OFS_DATA, d);
    if (arm) wr(NAC_OFS_CONTROL, {2'b00, m, 4'h4});
    wr(NAC_OFS_CONTROL, {2'b00, m, 4'h2});
    stall_len(n);
    chk("start stall", n, ok ? 8'h02 : 8'h00);
    if (ok) wait_idle;
    else begin
      rd(NAC_OFS_CONTROL, v);
      chk("start refused", {7'h00, v[NAC_BIT_START]}, 8'h00);
    end
    wr(NAC_OFS_CONTROL, 8'h01);
    stall_len(n);
    chk("read stall", n, 8'h04);
    rd(NAC_OFS_DATA, v);
    chk("read data", v, exp);
    rd(NAC_OFS_CONTROL, v);
    chk("read strobe clear", {7'h00, v[NAC_BIT_READ]}, 8'h00);
  endtask : prog

  // Main sequence
  initial begin
    reset_n = 1'b0;
    io_we = 1'b0;
    io_re = 1'b0;
    io_addr = 8'h00;
    io_wdata = 8'h00;
    gie = 1'b0;
    spm_req = 1'b0;
    err_count = 0;
    cmp_count = 0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    rd(NAC_OFS_CONTROL, v);
    chk("control reset", v, NAC_CONTROL_RESET);
    rd(NAC_OFS_DATA, v);
    chk("data reset", v, NAC_DATA_RESET);
    // Top byte of the space, the boundary of the address range
    wr(NAC_OFS_ADDR_LO, 8'hFF);
    wr(NAC_OFS_ADDR_HI, 8'h03);
    prog(2'h1, 8'h12, 8'hFF, 1'b1, 1'b1);
    prog(2'h2, 8'h5A, 8'h5A, 1'b1, 1'b1);
    prog(2'h0, 8'hC3, 8'hC3, 1'b1, 1'b1);
    prog(2'h3, 8'h00, 8'hC3, 1'b1, 1'b0);
    prog(2'h0, 8'h00, 8'hC3, 1'b0, 1'b0);
    spm_req <= 1'b1;
    prog(2'h0, 8'h00, 8'hC3, 1'b1, 1'b0);
    spm_req <= 1'b0;
    // Arm left to expire before the start request
    wr(NAC_OFS_CONTROL, 8'h04);
    repeat (6) @(posedge ref_clk);
    rd(NAC_OFS_CONTROL, v);
    chk("arm expired", v & 8'h04, 8'h00);
    wr(NAC_OFS_CONTROL, 8'h02);
    rd(NAC_OFS_CONTROL, v);
    chk("late start", v & 8'h02, 8'h00);
    // Mode and address writes while programming must be ignored
    wr(NAC_OFS_DATA, 8'h77);
    wr(NAC_OFS_CONTROL, 8'h04);
    wr(NAC_OFS_CONTROL, 8'h02);
    repeat (3) @(posedge ref_clk);
    wr(NAC_OFS_CONTROL, 8'h12);
    wr(NAC_OFS_ADDR_LO, 8'h00);
    rd(NAC_OFS_CONTROL, v);
    chk("mode held busy", v & 8'h32, 8'h02);
    wait_idle;
    wr(NAC_OFS_CONTROL, 8'h01);
    rd(NAC_OFS_DATA, v);
    chk("address held busy", v, 8'h77);
    // Ready interrupt: level while idle, gated during programming
    gie <= 1'b1;
    wr(NAC_OFS_CONTROL, 8'h08);
    repeat (2) @(posedge ref_clk);
    chk("irq idle", {7'h00, ready_irq}, 8'h01);
    wr(NAC_OFS_CONTROL, 8'h0C);
    wr(NAC_OFS_CONTROL, 8'h0A);
    repeat (2) @(posedge ref_clk);
    chk("irq busy", {7'h00, ready_irq}, 8'h00);
    wait_idle;
    repeat (2) @(posedge ref_clk);
    chk("irq done", {7'h00, ready_irq}, 8'h01);
    spm_req <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk("irq self program", {7'h00, ready_irq}, 8'h00);
    spm_req <= 1'b0;
    gie <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk("irq masked", {7'h00, ready_irq}, 8'h00);
    // Mode field cleared by a reset taken while idle
    wr(NAC_OFS_CONTROL, 8'h20);
    rd(NAC_OFS_CONTROL, v);
    chk("mode written", v, 8'h20);
    reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    rd(NAC_OFS_CONTROL, v);
    chk("mode after reset", v, 8'h00);
    report_and_stop;
  end
endmodule : nac_ctrl_bench
